// [hdl/aimc_clk_div.sv]
// aimc_clk_div: conversion clock enable, core clock divided by n+1.
// assumes divisor is a registered value on core_clk.
`timescale 1ns/10ps
module aimc_clk_div (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] divisor,
  output logic conv_tick
);
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic tick_q;
  wire logic at_end = (cnt_q >= divisor);
  // restart on reaching the divisor; a lowered divisor ends at once
  assign cnt_d = at_end ? aimc_pkg::DIV_CNT_INIT : cnt_q + 5'h01;
  assign conv_tick = tick_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= aimc_pkg::DIV_CNT_INIT;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= at_end;
    end
  end
endmodule : aimc_clk_div

// [hdl/aimc_mux_map.sv]
// aimc_mux_map: maps channel code and pair configuration to the
// positive and negative multiplexer inputs. purely combinational.
// assumes registered inputs from the register file.
`timescale 1ns/10ps
module aimc_mux_map (
  input wire logic [3:0] pair_cfg,
  input wire logic [2:0] channel_code,
  output logic [2:0] pos_pin,
  output logic [2:0] neg_pin,
  output logic differential
);
  wire logic [1:0] pair_idx = channel_code[2:1];
  wire logic odd_code = channel_code[0];
  wire logic [2:0] even_pin = {pair_idx, 1'b0};
  wire logic [2:0] odd_pin = {pair_idx, 1'b1};
  assign differential = pair_cfg[pair_idx];
  // even code: lower pin positive; odd code: polarity reversed
  assign pos_pin = !differential ? channel_code :
                   (odd_code ? odd_pin : even_pin);
  assign neg_pin = !differential ? 3'h0 :
                   (odd_code ? even_pin : odd_pin);
endmodule : aimc_mux_map

// [hdl/aimc_pkg.sv]
// aimc_pkg: register map, field layout and reset values of the
// converter input multiplexer and clock configuration block.
// assumes an 8-bit special function register port on core_clk.
package aimc_pkg;
  localparam logic [7:0] PAIR_CFG_ADDR = 8'hba;
  localparam logic [7:0] CHAN_SEL_ADDR = 8'hbb;
  localparam logic [7:0] CLK_GAIN_ADDR = 8'hbc;
  localparam logic [7:0] PAIR_CFG_RST = 8'h00;
  localparam logic [7:0] CHAN_SEL_RST = 8'h00;
  localparam logic [7:0] CLK_GAIN_RST = 8'hf8;
  localparam logic [7:0] PAIR_CFG_WMASK = 8'h0f;
  localparam logic [7:0] CHAN_SEL_WMASK = 8'h07;
  localparam logic [7:0] CLK_GAIN_WMASK = 8'hfb;
  localparam int DIV_LSB = 3;
  localparam int DIV_W = 5;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 2;
  localparam int CHAN_W = 3;
  localparam int PAIRS = 4;
  localparam int TRACK_CLOCKS = 3;
  localparam logic [1:0] TRACK_CNT_INIT = 2'h0;
  localparam logic [4:0] DIV_CNT_INIT = 5'h00;
  // settling after a multiplexer change, in ns, and in core clocks
  localparam int SETTLE_NS = 800;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam logic [4:0] SETTLE_INIT = 5'h00;
  typedef enum logic [1:0] {AIMC_IDLE, AIMC_TRACK, AIMC_CONV} aimc_state_t;
endpackage : aimc_pkg

// [hdl/aimc_top.sv]
// aimc_top: configuration registers for the small converter's input
// multiplexer, gain stage and conversion clock, plus the tracking
// sequence in low-power track mode.
// assumes a single-cycle sfr port: sfr_wr/sfr_rd with address on core_clk.
`timescale 1ns/10ps
module aimc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic low_power_track,
  input wire logic conv_start,
  input wire logic conv_done,
  output logic [2:0] pos_pin,
  output logic [2:0] neg_pin,
  output logic differential,
  output logic result_signed,
  output logic [1:0] amp_gain_code,
  output logic [4:0] conv_clock_divisor,
  output logic conv_tick,
  output logic tracking,
  output logic converting,
  output logic mux_settling
);
  logic [7:0] pair_config_reg_q;
  logic [7:0] channel_select_reg_q;
  logic [7:0] clock_gain_config_reg_q;
  logic [7:0] rdata_q;
  logic [1:0] track_cnt_q;
  logic [1:0] track_cnt_d;
  logic [4:0] settle_q;
  logic [4:0] settle_d;
  aimc_pkg::aimc_state_t state_q;
  aimc_pkg::aimc_state_t state_d;
  logic mux_diff;

  wire logic sel_pair = (sfr_addr == aimc_pkg::PAIR_CFG_ADDR);
  wire logic sel_chan = (sfr_addr == aimc_pkg::CHAN_SEL_ADDR);
  wire logic sel_clk = (sfr_addr == aimc_pkg::CLK_GAIN_ADDR);
  wire logic wr_pair = sfr_wr && sel_pair;
  wire logic wr_chan = sfr_wr && sel_chan;
  wire logic wr_clk = sfr_wr && sel_clk;
  // any write that can change the multiplexer restarts the settle count
  wire logic mux_change = wr_pair || wr_chan;
  logic [7:0] rd_mux;

  // reserved bits are held at zero in storage, so readback is zero
  always_comb begin
    if (sel_pair) begin
      rd_mux = pair_config_reg_q & aimc_pkg::PAIR_CFG_WMASK;
    end else if (sel_chan) begin
      rd_mux = channel_select_reg_q & aimc_pkg::CHAN_SEL_WMASK;
    end else if (sel_clk) begin
      rd_mux = clock_gain_config_reg_q & aimc_pkg::CLK_GAIN_WMASK;
    end else begin
      rd_mux = 8'h00;
    end
  end

  assign sfr_hit = sel_pair || sel_chan || sel_clk;
  assign sfr_rdata = rdata_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pair_config_reg_q <= aimc_pkg::PAIR_CFG_RST;
      channel_select_reg_q <= aimc_pkg::CHAN_SEL_RST;
      clock_gain_config_reg_q <= aimc_pkg::CLK_GAIN_RST;
      rdata_q <= 8'h00;
    end else begin
      if (wr_pair) begin
        pair_config_reg_q <= sfr_wdata & aimc_pkg::PAIR_CFG_WMASK;
      end
      if (wr_chan) begin
        channel_select_reg_q <= sfr_wdata & aimc_pkg::CHAN_SEL_WMASK;
      end
      if (wr_clk) begin
        clock_gain_config_reg_q <= sfr_wdata & aimc_pkg::CLK_GAIN_WMASK;
      end
      if (sfr_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign conv_clock_divisor =
    clock_gain_config_reg_q[aimc_pkg::DIV_LSB +: aimc_pkg::DIV_W];
  // 00:0.5 01:1 10:2 11:4, decoded in the analog gain stage
  assign amp_gain_code =
    clock_gain_config_reg_q[aimc_pkg::GAIN_LSB +: aimc_pkg::GAIN_W];

  aimc_clk_div u_div (
    .core_clk(core_clk),
    .rst(rst),
    .divisor(conv_clock_divisor),
    .conv_tick(conv_tick)
  );

  aimc_mux_map u_map (
    .pair_cfg(pair_config_reg_q[aimc_pkg::PAIRS-1:0]),
    .channel_code(channel_select_reg_q[aimc_pkg::CHAN_W-1:0]),
    .pos_pin(pos_pin),
    .neg_pin(neg_pin),
    .differential(mux_diff)
  );
  assign differential = mux_diff;
  assign result_signed = mux_diff;

  // settle timer is advisory only: software still owns the wait
  assign settle_d = mux_change ? 5'(aimc_pkg::SETTLE_CYCLES) :
                    (settle_q != aimc_pkg::SETTLE_INIT) ?
                    settle_q - 5'h01 : settle_q;
  assign mux_settling = (settle_q != aimc_pkg::SETTLE_INIT);

  // track/convert sequence; normal mode skips straight to conversion
  always_comb begin
    state_d = state_q;
    track_cnt_d = track_cnt_q;
    case (state_q)
      aimc_pkg::AIMC_IDLE: begin
        if (conv_start) begin
          track_cnt_d = aimc_pkg::TRACK_CNT_INIT;
          state_d = low_power_track ? aimc_pkg::AIMC_TRACK :
                    aimc_pkg::AIMC_CONV;
        end
      end
      aimc_pkg::AIMC_TRACK: begin
        if (conv_tick) begin
          if (track_cnt_q == 2'(aimc_pkg::TRACK_CLOCKS - 1)) begin
            state_d = aimc_pkg::AIMC_CONV;
          end else begin
            track_cnt_d = track_cnt_q + 2'h1;
          end
        end
      end
      aimc_pkg::AIMC_CONV: begin
        if (conv_done) begin
          state_d = aimc_pkg::AIMC_IDLE;
        end
      end
      default: begin
        state_d = aimc_pkg::AIMC_IDLE;
      end
    endcase
  end

  // normal mode tracks whenever idle; low-power mode only when sequenced
  assign tracking = (state_q == aimc_pkg::AIMC_TRACK) ||
                    (!low_power_track && state_q == aimc_pkg::AIMC_IDLE);
  assign converting = (state_q == aimc_pkg::AIMC_CONV);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= aimc_pkg::AIMC_IDLE;
      track_cnt_q <= aimc_pkg::TRACK_CNT_INIT;
      settle_q <= aimc_pkg::SETTLE_INIT;
    end else begin
      state_q <= state_d;
      track_cnt_q <= track_cnt_d;
      settle_q <= settle_d;
    end
  end
endmodule : aimc_top

// [tb/aimc_host.sv]
// aimc_host: processor side of the register port.
// assumes core_clk from the bench; strobes launch 5 ns after an edge.
`timescale 1ns/10ps
module aimc_host (
  input wire logic core_clk,
  input wire logic [7:0] sfr_rdata,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic [7:0] sfr_wdata,
  output logic sfr_rd
);
  initial {sfr_addr, sfr_wr, sfr_wdata, sfr_rd} = 18'h0_0000;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #5 {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    @(posedge core_clk);
    #5 sfr_wr = 1'b0;
    // results after a mux change are not trusted before settling
    if (a == 8'hba || a == 8'hbb)
      repeat (aimc_pkg::SETTLE_CYCLES) @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #5 {sfr_addr, sfr_rd} = {a, 1'b1};
    @(posedge core_clk);
    #5 sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd
endmodule : aimc_host

// [tb/aimc_top_asserts.sv]
// aimc_chk: port-level checks of the converter config block.
// assumes bind onto aimc_top, one clock domain on core_clk.
`timescale 1ns/10ps
module aimc_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic [2:0] pos_pin,
  input wire logic [2:0] neg_pin,
  input wire logic differential,
  input wire logic [1:0] amp_gain_code,
  input wire logic [4:0] conv_clock_divisor,
  input wire logic conv_tick,
  input wire logic tracking,
  input wire logic converting,
  input wire logic low_power_track,
  input wire logic mux_settling
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [1:0] trk_q;
  logic [7:0] wd_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trk_q <= 2'h0;
      wd_q <= 8'h00;
    end else begin
      trk_q <= tracking ? trk_q + 2'(conv_tick) : 2'h0;
      wd_q <= sfr_wdata;
    end
  end
  a_pair_rd_zero: assert property (
    sfr_rd && sfr_addr == 8'hba |=> sfr_rdata[7:4] == 4'h0) else $error("pair");
  a_chan_rd_zero: assert property (
    sfr_rd && sfr_addr == 8'hbb |=> sfr_rdata[7:3] == 5'h00) else $error("chan");
  a_cfg_bit_zero: assert property (
    sfr_rd && sfr_addr == 8'hbc |=> !sfr_rdata[2]) else $error("bit2");
  a_cfg_write: assert property (
    sfr_wr && sfr_addr == 8'hbc |=> conv_clock_divisor == wd_q[7:3]
    && amp_gain_code == wd_q[1:0]) else $error("cfg wr");
  a_chan_write: assert property (
    sfr_wr && sfr_addr == 8'hbb |=> pos_pin == wd_q[2:0]) else $error("sel");
  a_neg_pin_map: assert property (
    neg_pin == (differential ? pos_pin ^ 3'h1 : 3'h0)) else $error("neg");
  a_tick_period: assert property (
    conv_tick && conv_clock_divisor == 5'h02 |=> !conv_tick ##1 !conv_tick
    ##1 conv_tick) else $error("tick");
  // normal-mode tracking also drops on a mode change; only a sequenced
  // low-power track that hands over to conversion is counted
  a_track_three: assert property (
    $fell(tracking) && converting && low_power_track |-> trk_q == 2'h3)
    else $error("track");
  a_settle_window: assert property (
    sfr_wr && (sfr_addr == 8'hba || sfr_addr == 8'hbb) |=> mux_settling
    ##15 mux_settling ##1 !mux_settling) else $error("settle");
endmodule : aimc_chk
bind aimc_top aimc_chk u_chk (.core_clk(core_clk), .rst(rst),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .pos_pin(pos_pin),
  .neg_pin(neg_pin), .differential(differential),
  .amp_gain_code(amp_gain_code), .conv_clock_divisor(conv_clock_divisor),
  .conv_tick(conv_tick), .tracking(tracking), .converting(converting),
  .low_power_track(low_power_track), .mux_settling(mux_settling));

// [tb/aimc_top_tb.sv]
// aimc_top_tb: register, mux map, clock and tracking sequences.
// assumes aimc_host as bus master and the bound checker.
`timescale 1ns/10ps
module aimc_top_tb;
  // divisor for at most 7.5 MHz from 20 MHz, ratio rounded up
  localparam int DIV = (20000 + 7500 - 1) / 7500 - 1;
  logic core_clk, rst, low_power_track, conv_start, conv_done, p;
  logic sfr_wr, sfr_rd, sfr_hit, differential, result_signed, conv_tick;
  logic tracking, converting;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
  logic [7:0] rv[4] = '{8'h00, 8'h00, 8'hf8, 8'h00};
  logic [7:0] wm[4] = '{8'h0f, 8'h07, 8'hfb, 8'h00};
  logic [2:0] pos_pin, neg_pin;
  logic [1:0] amp_gain_code;
  logic [4:0] conv_clock_divisor;
  int fails = 0;
  int checked = 0;
  int n, m;
  aimc_top dut (.core_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
    .sfr_rdata, .sfr_hit, .low_power_track, .conv_start, .conv_done,
    .pos_pin, .neg_pin, .differential, .result_signed, .amp_gain_code,
    .conv_clock_divisor, .conv_tick, .tracking, .converting,
    .mux_settling());
  aimc_host host (.core_clk, .sfr_rdata, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_rd);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input string s, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic pulse(ref logic s);
    @(posedge core_clk);
    #5 s = 1'b1;
    @(posedge core_clk);
    #5 s = 1'b0;
  endtask : pulse
  initial begin
    {rst, low_power_track, conv_start, conv_done} = 4'b1000;
    repeat (10) @(posedge core_clk);
    #5 rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      host.rd(8'hba + 8'(i), v);
      chk("reset", v, rv[i]);
      host.wr(8'hba + 8'(i), 8'hff);
      host.rd(8'hba + 8'(i), v);
      chk("mask", v, wm[i]);
      chk("hit", {7'h00, sfr_hit}, 8'(i != 3));
    end
    for (int c = 0; c < 16; c++) begin
      host.wr(8'hba, 8'(c));
      for (int k = 0; k < 8; k++) begin
        host.wr(8'hbb, 8'(k) | 8'hf8);
        p = c[k / 2];
        chk("mux", {differential, result_signed, pos_pin, neg_pin},
          {p, p, 3'(k), p ? 3'(k ^ 1) : 3'h0});
      end
    end
    for (int g = 0; g < 4; g++) begin
      host.wr(8'hbc, {5'(DIV), 1'b1, 2'(g)});
      chk("gain", {1'b0, conv_clock_divisor, amp_gain_code},
        {1'b0, 5'(DIV), 2'(g)});
    end
    for (n = 0; !conv_tick && n < 40; n++) @(posedge core_clk) #5;
    chk("tick", {7'h00, conv_tick}, 8'h01);
    n = 0;
    do @(posedge core_clk) #5 n++; while (!conv_tick && n < 40);
    chk("period", 8'(n), 8'(DIV + 1));
    low_power_track = 1'b1;
    pulse(conv_start);
    n = 0;
    for (m = 0; tracking && m < 40; m++) begin
      n += int'(conv_tick);
      @(posedge core_clk) #5;
    end
    chk("track", {7'h00, converting} + 8'(n), 8'(aimc_pkg::TRACK_CLOCKS + 1));
    pulse(conv_done);
    chk("done", {7'h00, converting}, 8'h00);
    rst = 1'b1;
    @(posedge core_clk) #5 rst = 1'b0;
    host.rd(8'hbc, v);
    chk("rerst", v, 8'hf8);
    close_out();
  end
endmodule : aimc_top_tb
